// [logic/hrl_sender.sv]
`timescale 1ns/1ps
// How it works
// - Check char is XOR of every checked character from a zero accumulator.
// - Checked span starts after start-of-text and includes end-of-text.
// - Check char goes out right after end-of-text.
// - Enquiry, host ack, then framed record, host ack completes delivery.
// - After busy reply, enquire again after 5 s, up to 4 busy replies.
// - Unanswered enquiry is repeated every 5 s, at most four sent.
// - Frame refused: wait 3 s, enquire again, resend; three attempts total.
// - No frame reply in 11 s: enquire again and resend; same limit.
// - After three failed attempts divert to printer, take next record.
// - Plain record: 4-byte id, extension, 6-byte charge, 10-byte number.
// - Plain record ends in one carriage return, never a line feed.
// - Charge in cents without point; number always ten digits.
// - Plain acknowledge codes are settable, default y and n.
// - Plain refusal: wait 3 s and resend once as final attempt.
// - Final plain failure warns; optionally keeps record queued for retry.
// - No plain acknowledge within 5 s: full report to printer.
// - Enquiry character is value five.
// - Start-of-text is two and clears the check; end-of-text is three.
module hrl_sender
  import hrl_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic      [7:0]  tx_data_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  output logic             prn_divert_o,
  output logic             warn_o
);
  hrl_state_t  st_q;
  logic [3:0]  ctrl_q;
  logic [7:0]  pack_q;
  logic [7:0]  pnak_q;
  logic [5:0]  len_q;
  logic [4:0]  wptr_q;
  logic [7:0]  buf_q [32];
  logic        go_q;
  logic        dph_q;
  logic        dwr_q;
  logic [7:0]  dofs_q;
  logic        plain_q;
  logic        final_q;
  logic        last_q;
  logic        hold_pln_q;
  logic [3:0]  hold_lim_q;
  logic [5:0]  idx_q;
  logic [2:0]  enq_nak_q;
  logic [2:0]  enq_sil_q;
  logic [2:0]  tries_q;
  logic        done_q;
  logic        div_q;
  logic        queued_q;
  logic [7:0]  bcc_q;
  logic [27:0] tick_cnt_q;
  logic        tick_q;
  logic [3:0]  sec_q;
  logic        tmr_clr_q;
  logic [7:0]  cur_char;
  logic [5:0]  last_idx;
  logic        sending;
  logic        issue;
  logic        char_sent;
  logic [31:0] rd_val;

  assign sending   = (st_q == S_ENQ) || (st_q == S_FRM) || (st_q == S_PLN);
  assign issue     = sending && !tx_valid_o && !last_q;
  assign char_sent = tx_valid_o && tx_ready_i;

  // Register read mux
  always_comb
  begin
    rd_val = '0;
    unique case (haddr_i[7:0])
      OFS_CTRL:  rd_val = {28'h0000000, ctrl_q};
      OFS_CODES: rd_val = {16'h0000, pnak_q, pack_q};
      OFS_LEN:   rd_val = {26'h0, len_q};
      OFS_STAT:  rd_val = {16'h0000, 1'b0, tries_q, 1'b0, enq_nak_q,
                           2'b00, queued_q, warn_o, div_q, done_q,
                           1'b0, (st_q != S_IDLE)};
      default:   rd_val = '0;
    endcase
  end

  // AHB-Lite slave, zero wait states
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dph_q       <= 1'b0;
      dwr_q       <= 1'b0;
      dofs_q      <= '0;
      hrdata_o    <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else if (hready_i)
    begin
      dph_q  <= hsel_i && htrans_i[1];
      dwr_q  <= hsel_i && htrans_i[1] && hwrite_i;
      dofs_q <= haddr_i[7:0];
      if (hsel_i && htrans_i[1] && !hwrite_i)
        hrdata_o <= rd_val;
    end
  end

  // Register writes
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_q <= CTRL_RST;
      pack_q <= PACK_RST;
      pnak_q <= PNAK_RST;
      len_q  <= LEN_RST;
      wptr_q <= '0;
      go_q   <= 1'b0;
    end
    else
    begin
      go_q <= 1'b0;
      if (dph_q && dwr_q)
      begin
        unique case (dofs_q)
          OFS_CTRL:
          begin
            ctrl_q <= {1'b0, 1'b0, hwdata_i[CTRL_REQ], hwdata_i[CTRL_MODE]};
            go_q   <= hwdata_i[CTRL_GO];
            if (hwdata_i[CTRL_CLR])
              wptr_q <= '0;
          end
          OFS_CODES:
          begin
            pack_q <= hwdata_i[7:0];
            pnak_q <= hwdata_i[15:8];
          end
          OFS_LEN:  len_q  <= (hwdata_i[5:0] > 6'd32) ? 6'd32 : hwdata_i[5:0];
          OFS_DATA: wptr_q <= wptr_q + 5'd1;
          default:  ;
        endcase
      end
    end
  end

  // Record text buffer
  always_ff @(posedge clk_i)
  begin
    if (dph_q && dwr_q && (dofs_q == OFS_DATA))
      buf_q[wptr_q] <= hwdata_i[7:0];
  end

  // Next character to send
  always_comb
  begin
    cur_char = CH_ENQ;
    last_idx = '0;
    if (st_q == S_FRM)
    begin
      last_idx = len_q + 6'd2;
      if (idx_q == 6'd0)
        cur_char = CH_STX;
      else if (idx_q <= len_q)
        cur_char = buf_q[5'(idx_q - 6'd1)];
      else if (idx_q == len_q + 6'd1)
        cur_char = CH_ETX;
      else
        cur_char = bcc_q;
    end
    else if (st_q == S_PLN)
    begin
      last_idx = PLN_LAST;
      if (idx_q < PLN_ID_LEN)
        cur_char = START_ID[5'(6'd31 - (idx_q << 3)) -: 8];
      else if (idx_q < PLN_LAST)
        cur_char = buf_q[5'(idx_q - PLN_ID_LEN)];
      else
        cur_char = CH_CR;
    end
  end

  // Character output
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= '0;
    end
    else if (char_sent)
      tx_valid_o <= 1'b0;
    else if (issue)
    begin
      tx_valid_o <= 1'b1;
      tx_data_o  <= cur_char;
    end
  end

  // Block check accumulator
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      bcc_q <= '0;
    else if (issue && (st_q == S_FRM))
    begin
      if (idx_q == 6'd0)
        bcc_q <= '0;
      else if (idx_q <= len_q + 6'd1)
        bcc_q <= bcc_q ^ cur_char;
    end
  end

  // Seconds tick and timeout counter
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
      sec_q      <= '0;
    end
    else if (char_sent || tmr_clr_q)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
      sec_q      <= '0;
    end
    else
    begin
      tick_q     <= (tick_cnt_q == 28'(TICK_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == 28'(TICK_CYC - 1)) ? '0
                                                      : tick_cnt_q + 28'd1;
      if (tick_q && (sec_q != 4'hF))
        sec_q <= sec_q + 4'd1;
    end
  end

  // Protocol sequencer
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q <= S_IDLE;
      {plain_q, final_q, last_q, hold_pln_q, tmr_clr_q} <= '0;
      {done_q, div_q, queued_q, warn_o, prn_divert_o}   <= '0;
      hold_lim_q <= '0;
      idx_q      <= '0;
      enq_nak_q  <= '0;
      enq_sil_q  <= '0;
      tries_q    <= '0;
    end
    else
    begin
      tmr_clr_q    <= 1'b0;
      prn_divert_o <= 1'b0;
      unique case (st_q)
        S_IDLE:
          if (go_q)
          begin
            plain_q <= ctrl_q[CTRL_MODE];
            {final_q, last_q, done_q, div_q, queued_q, warn_o} <= '0;
            {enq_nak_q, enq_sil_q, tries_q} <= '0;
            idx_q <= '0;
            st_q  <= ctrl_q[CTRL_MODE] ? S_PLN : S_ENQ;
          end
        S_ENQ, S_FRM, S_PLN:
        begin
          if (issue)
          begin
            idx_q  <= idx_q + 6'd1;
            last_q <= (idx_q == last_idx);
          end
          if (char_sent && last_q)
          begin
            last_q <= 1'b0;
            idx_q  <= '0;
            st_q   <= (st_q == S_ENQ) ? S_WENQ :
                      (st_q == S_FRM) ? S_WFRM : S_WPLN;
          end
        end
        S_WENQ:
          if (rx_valid_i && (rx_data_i == CH_ACK))
          begin
            {enq_nak_q, enq_sil_q} <= '0;
            st_q <= S_FRM;
          end
          else if (rx_valid_i && (rx_data_i == CH_NAK))
          begin
            enq_nak_q <= enq_nak_q + 3'd1;
            if (enq_nak_q + 3'd1 >= ENQ_NAK_MAX)
            begin
              div_q <= 1'b1;
              prn_divert_o <= 1'b1;
              st_q <= S_IDLE;
            end
            else
            begin
              {hold_pln_q, hold_lim_q, tmr_clr_q} <= {1'b0, ENQ_WAIT_S, 1'b1};
              st_q <= S_HOLD;
            end
          end
          else if (sec_q >= ENQ_WAIT_S)
          begin
            enq_sil_q <= enq_sil_q + 3'd1;
            if (enq_sil_q + 3'd1 >= ENQ_SIL_MAX)
            begin
              div_q <= 1'b1;
              prn_divert_o <= 1'b1;
              st_q <= S_IDLE;
            end
            else
              st_q <= S_ENQ;
          end
        S_WFRM:
          if (rx_valid_i && (rx_data_i == CH_ACK))
          begin
            done_q <= 1'b1;
            st_q   <= S_IDLE;
          end
          else if ((rx_valid_i && (rx_data_i == CH_NAK)) ||
                   (sec_q >= FRM_WAIT_S))
          begin
            tries_q <= tries_q + 3'd1;
            if (tries_q + 3'd1 >= FRM_TRY_MAX)
            begin
              div_q <= 1'b1;
              prn_divert_o <= 1'b1;
              st_q <= S_IDLE;
            end
            else if (rx_valid_i)
            begin
              {hold_pln_q, hold_lim_q, tmr_clr_q} <= {1'b0, FRM_NAK_S, 1'b1};
              st_q <= S_HOLD;
            end
            else
              st_q <= S_ENQ;
          end
        S_WPLN:
          if (rx_valid_i && (rx_data_i == pack_q))
          begin
            done_q <= 1'b1;
            st_q   <= S_IDLE;
          end
          else if (rx_valid_i && (rx_data_i == pnak_q))
          begin
            if (!final_q)
            begin
              final_q <= 1'b1;
              {hold_pln_q, hold_lim_q, tmr_clr_q} <= {1'b1, PLN_NAK_S, 1'b1};
              st_q <= S_HOLD;
            end
            else
            begin
              warn_o   <= 1'b1;
              queued_q <= ctrl_q[CTRL_REQ];
              st_q     <= S_IDLE;
            end
          end
          else if (sec_q >= PLN_WAIT_S)
          begin
            div_q        <= 1'b1;
            prn_divert_o <= 1'b1;
            warn_o       <= final_q;
            queued_q     <= final_q && ctrl_q[CTRL_REQ];
            st_q         <= S_IDLE;
          end
        S_HOLD:
          if (!tmr_clr_q && (sec_q >= hold_lim_q))
            st_q <= hold_pln_q ? S_PLN : S_ENQ;
      endcase
    end
  end

  property p_stx_clears;
    @(posedge clk_i) disable iff (!arst_n_i)
    (issue && st_q == S_FRM && idx_q == 6'd0) |=> (bcc_q == 8'h00);
  endproperty
  a_stx_clears: assert property (p_stx_clears)
    else $error("check not cleared at start of text");

  property p_bcc_follows;
    @(posedge clk_i) disable iff (!arst_n_i)
    (issue && st_q == S_FRM && idx_q == len_q + 6'd2)
      |=> (tx_data_o == $past(bcc_q) && tx_valid_o);
  endproperty
  a_bcc_follows: assert property (p_bcc_follows)
    else $error("check char not sent after end of text");

  property p_etx_accum;
    @(posedge clk_i) disable iff (!arst_n_i)
    (issue && st_q == S_FRM && idx_q == len_q + 6'd1)
      |=> (bcc_q == ($past(bcc_q) ^ CH_ETX));
  endproperty
  a_etx_accum: assert property (p_etx_accum)
    else $error("end of text missing from check");

  property p_enq_code;
    @(posedge clk_i) disable iff (!arst_n_i)
    (issue && st_q == S_ENQ) |=> (tx_data_o == CH_ENQ);
  endproperty
  a_enq_code: assert property (p_enq_code)
    else $error("enquiry code wrong");

  property p_cr_end;
    @(posedge clk_i) disable iff (!arst_n_i)
    (issue && st_q == S_PLN && idx_q == PLN_LAST)
      |=> (tx_data_o == CH_CR) ##1 (!issue)[*2];
  endproperty
  a_cr_end: assert property (p_cr_end)
    else $error("plain record not closed by one return");

  property p_limits;
    @(posedge clk_i) disable iff (!arst_n_i)
    (enq_nak_q <= ENQ_NAK_MAX) && (tries_q <= FRM_TRY_MAX)
      && (enq_sil_q <= ENQ_SIL_MAX);
  endproperty
  a_limits: assert property (p_limits)
    else $error("retry count beyond limit");

  property p_mode;
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_q inside {S_PLN, S_WPLN}) |-> plain_q;
  endproperty
  a_mode: assert property (p_mode)
    else $error("plain sequence outside plain mode");

  property p_timer_restart;
    @(posedge clk_i) disable iff (!arst_n_i)
    char_sent |=> (sec_q == 4'h0 && tick_cnt_q == 28'h0000000);
  endproperty
  a_timer_restart: assert property (p_timer_restart)
    else $error("timer not restarted by sent character");

  property p_pln_timeout;
    @(posedge clk_i) disable iff (!arst_n_i)
    (st_q == S_WPLN && !rx_valid_i && sec_q >= PLN_WAIT_S)
      |=> (prn_divert_o && st_q == S_IDLE);
  endproperty
  a_pln_timeout: assert property (p_pln_timeout)
    else $error("missing printer divert after plain timeout");
endmodule

// [logic/hrl_pkg.sv]
package hrl_pkg;
  // Link characters
  localparam logic [7:0]  CH_ENQ = 8'h05;
  localparam logic [7:0]  CH_STX = 8'h02;
  localparam logic [7:0]  CH_ETX = 8'h03;
  localparam logic [7:0]  CH_CR  = 8'h0D;
  localparam logic [7:0]  CH_ACK = 8'h06;
  localparam logic [7:0]  CH_NAK = 8'h15;
  localparam logic [7:0]  PACK_RST = 8'h79;
  localparam logic [7:0]  PNAK_RST = 8'h6E;
  localparam logic [31:0] START_ID = 32'h61633031;
  // Register offsets
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_CODES = 8'h04;
  localparam logic [7:0]  OFS_LEN   = 8'h08;
  localparam logic [7:0]  OFS_DATA  = 8'h0C;
  localparam logic [7:0]  OFS_STAT  = 8'h10;
  // Control fields
  localparam int          CTRL_MODE = 0;
  localparam int          CTRL_REQ  = 1;
  localparam int          CTRL_GO   = 2;
  localparam int          CTRL_CLR  = 3;
  localparam logic [3:0]  CTRL_RST  = 4'h0;
  localparam logic [5:0]  LEN_RST   = 6'h00;
  // Timing
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          TICK_S        = 1;
  localparam int          TICK_CYCLES   = TICK_S * 1000000000 / CLK_PERIOD_NS;
  localparam logic [3:0]  ENQ_WAIT_S    = 4'h5;
  localparam logic [3:0]  FRM_NAK_S     = 4'h3;
  localparam logic [3:0]  FRM_WAIT_S    = 4'hB;
  localparam logic [3:0]  PLN_NAK_S     = 4'h3;
  localparam logic [3:0]  PLN_WAIT_S    = 4'h5;
  // Retry limits and layout
  localparam logic [2:0]  ENQ_NAK_MAX   = 3'h4;
  localparam logic [2:0]  ENQ_SIL_MAX   = 3'h4;
  localparam logic [2:0]  FRM_TRY_MAX   = 3'h3;
  localparam logic [5:0]  PLN_ID_LEN    = 6'h04;
  localparam logic [5:0]  PLN_LAST      = 6'h18;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_ENQ  = 8'h02,
    S_WENQ = 8'h04,
    S_FRM  = 8'h08,
    S_WFRM = 8'h10,
    S_PLN  = 8'h20,
    S_WPLN = 8'h40,
    S_HOLD = 8'h80
  } hrl_state_t;
endpackage

// [bench/hrl_host_model.sv]
`timescale 1ns/1ps
module hrl_host_model
  import hrl_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             clr_i,
  input  wire logic             mode_i,
  input  wire logic             slow_i,
  input  wire logic [7:0][8:0]  script_i,
  input  wire logic [7:0]       tx_data_i,
  input  wire logic             tx_valid_i,
  output logic                  tx_ready_o,
  output logic      [7:0]       rx_data_o,
  output logic                  rx_valid_o,
  output logic      [7:0]       nlog_o,
  output logic      [63:0][7:0] log_o,
  output logic      [63:0][15:0] stamp_o
);
  logic [15:0] cyc_q;
  logic [2:0]  idx_q;
  logic [2:0]  dly_q;
  logic        pend_q;
  logic        in_frm_q;
  logic        aft_etx_q;
  logic        eom;

  // End of a message that the host answers
  assign eom = mode_i ? (tx_data_i == CH_CR) :
               (aft_etx_q || (!in_frm_q && tx_data_i == CH_ENQ));

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cyc_q      <= 16'h0000;
      idx_q      <= 3'h0;
      dly_q      <= 3'h0;
      pend_q     <= 1'b0;
      in_frm_q   <= 1'b0;
      aft_etx_q  <= 1'b0;
      tx_ready_o <= 1'b0;
      rx_data_o  <= 8'h00;
      rx_valid_o <= 1'b0;
      nlog_o     <= 8'h00;
      log_o      <= '0;
      stamp_o    <= '0;
    end
    else
    begin
      cyc_q      <= cyc_q + 16'h0001;
      tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
      rx_valid_o <= 1'b0;
      rx_data_o  <= ~rx_data_o;
      if (clr_i)
      begin
        nlog_o    <= 8'h00;
        idx_q     <= 3'h0;
        pend_q    <= 1'b0;
        in_frm_q  <= 1'b0;
        aft_etx_q <= 1'b0;
      end
      else if (tx_valid_i && tx_ready_o)
      begin
        log_o[nlog_o]   <= tx_data_i;
        stamp_o[nlog_o] <= cyc_q;
        nlog_o          <= nlog_o + 8'h01;
        if (eom)
        begin
          pend_q <= 1'b1;
          dly_q  <= 3'h4;
        end
        if (aft_etx_q)
        begin
          in_frm_q  <= 1'b0;
          aft_etx_q <= 1'b0;
        end
        else if (in_frm_q && tx_data_i == CH_ETX)
          aft_etx_q <= 1'b1;
        else if (!in_frm_q && tx_data_i == CH_STX)
          in_frm_q <= 1'b1;
      end
      else if (pend_q)
      begin
        if (dly_q != 3'h0)
          dly_q <= dly_q - 3'h1;
        else
        begin
          // Scripted reply: ack, busy or refusal code, or silence
          pend_q <= 1'b0;
          idx_q  <= idx_q + 3'h1;
          if (script_i[idx_q][8])
          begin
            rx_valid_o <= 1'b1;
            rx_data_o  <= script_i[idx_q][7:0];
          end
        end
      end
    end
  end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import hrl_pkg::*;
;
  localparam int         T = 20;
  localparam logic [8:0] A = 9'h106;
  localparam logic [8:0] N = 9'h115;
  localparam logic [8:0] S = 9'h000;
  localparam logic [8:0] Y = 9'h179;
  localparam logic [8:0] K = 9'h14B;

  logic              clk_i;
  logic              arst_n_i;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  logic [7:0]        tx_data;
  logic              tx_valid;
  logic              tx_ready;
  logic [7:0]        rx_data;
  logic              rx_valid;
  logic              prn;
  logic              warn;
  logic              clr;
  logic              mode;
  logic              slow;
  logic [7:0][8:0]   script;
  logic [7:0]        nlog;
  logic [63:0][7:0]  log;
  logic [63:0][15:0] stamp;
  logic [7:0]        exp_q[$];
  logic [31:0]       v;
  logic [4:0][7:0]   ofs = {8'h40, OFS_STAT, OFS_LEN, OFS_CODES, OFS_CTRL};
  logic [4:0][31:0]  rstv = {64'h0, 32'h0, {16'h0, PNAK_RST, PACK_RST}, 32'h0};
  int                fails = 0;
  int                tests_run = 0;
  int                ndiv = 0;
  int                d0;
  int                i;

  hrl_sender #(.TICK_CYC(T)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .tx_data_o(tx_data),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .rx_data_i(rx_data),
    .rx_valid_i(rx_valid), .prn_divert_o(prn), .warn_o(warn));

  hrl_host_model host_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .clr_i(clr), .mode_i(mode),
    .slow_i(slow), .script_i(script), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .nlog_o(nlog), .log_o(log), .stamp_o(stamp));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
    if (prn === 1'b1)
      ndiv <= ndiv + 1;

  task test_done;
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task gap(input int a, input int b, input int s);
    int g;
    g = int'(stamp[b]) - int'(stamp[a]);
    if (g >= (s - 1) * T && g <= s * T + 16)
      g = s * T;
    chk("gap", g, s * T);
  endtask

  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
  endtask

  task bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task fill(input int n, input logic [7:0] base, input logic [3:0] ctl);
    int k;
    bus_wr(OFS_CTRL, {28'h0, ctl | 4'h8});
    bus_wr(OFS_LEN, n);
    for (k = 0; k < n; k++)
      bus_wr(OFS_DATA, {24'h0, base + 8'(k)});
  endtask

  task go(input logic [3:0] ctl, input logic [7:0][8:0] scr);
    int k;
    d0 = ndiv;
    script <= scr;
    mode   <= ctl[0];
    clr    <= 1'b1;
    bus_wr(OFS_CTRL, {28'h0, ctl});
    clr    <= 1'b0;
    bus_wr(OFS_CTRL, {28'h0, ctl | 4'h4});
    repeat (8) @(posedge clk_i);
    for (k = 0; k < 3000; k++)
    begin
      bus_rd(OFS_STAT, v);
      if (v[0] === 1'b0 || v[4] === 1'b1)
        break;
    end
    chk("finished", {31'h0, ~v[0] | v[4]}, 32'h1);
  endtask

  task exp_frame(input int n, input logic [7:0] base);
    logic [7:0] b;
    logic [7:0] bcc;
    int k;
    exp_q.push_back(CH_ENQ);
    exp_q.push_back(CH_STX);
    bcc = 8'h00;
    for (k = 0; k < n; k++)
    begin
      b = base + 8'(k);
      exp_q.push_back(b);
      bcc = bcc ^ b;
    end
    exp_q.push_back(CH_ETX);
    exp_q.push_back(bcc ^ CH_ETX);
  endtask

  task exp_plain(input int n, input logic [7:0] base);
    int k;
    for (k = 3; k >= 0; k--)
      exp_q.push_back(START_ID[k*8 +: 8]);
    for (k = 0; k < n; k++)
      exp_q.push_back(base + 8'(k));
    exp_q.push_back(CH_CR);
  endtask

  task chk_log;
    int k;
    chk("count", {24'h0, nlog}, exp_q.size());
    for (k = 0; k < exp_q.size(); k++)
      chk("char", {24'h0, log[k]}, {24'h0, exp_q[k]});
    exp_q.delete();
  endtask

  initial
  begin
    #100000;
    fails++;
    test_done;
  end

  initial
  begin
    arst_n_i = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    clr = 1'b0;
    mode = 1'b0;
    slow = 1'b0;
    script = '0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    chk("idle out", {28'h0, hreadyout, tx_valid, warn, hresp}, 32'h8);
    for (i = 0; i < 5; i++)
    begin
      bus_rd(ofs[i], v);
      chk("reset reg", v, rstv[i]);
    end
    // Framed delivery, transmitter stalling
    slow <= 1'b1;
    fill(3, 8'h31, 4'h0);
    go(4'h0, {S, S, S, S, S, S, A, A});
    slow <= 1'b0;
    exp_frame(3, 8'h31);
    chk_log;
    bus_rd(OFS_STAT, v);
    chk("done", {31'h0, v[2]}, 32'h1);
    // Busy host, then silent host
    for (i = 0; i < 2; i++)
    begin
      go(4'h0, i == 0 ? {S, S, S, S, N, N, N, N} : '0);
      repeat (4) exp_q.push_back(CH_ENQ);
      chk_log;
      gap(0, 1, 5);
      gap(2, 3, 5);
      bus_rd(OFS_STAT, v);
      chk("busy count", v[10:8], i == 0 ? 32'h4 : 32'h0);
      chk("enq divert", ndiv - d0, 32'h1);
    end
    // Frame refused three times
    go(4'h0, {S, S, N, A, N, A, N, A});
    repeat (3) exp_frame(3, 8'h31);
    chk_log;
    gap(6, 7, 3);
    bus_rd(OFS_STAT, v);
    chk("tries", v[14:12], 32'h3);
    chk("frame divert", ndiv - d0, 32'h1);
    // Frame unanswered once
    go(4'h0, {S, S, S, S, A, A, S, A});
    repeat (2) exp_frame(3, 8'h31);
    chk_log;
    gap(6, 7, 11);
    chk("no divert", ndiv - d0, 32'h0);
    // Plain record, default acknowledge
    fill(20, 8'h30, 4'h1);
    go(4'h1, {S, S, S, S, S, S, S, Y});
    exp_plain(20, 8'h30);
    chk_log;
    chk("plain divert", ndiv - d0, 32'h0);
    // Plain record unanswered
    go(4'h1, '0);
    exp_plain(20, 8'h30);
    chk_log;
    chk("report", ndiv - d0, 32'h1);
    // Custom codes, refused twice, requeue set
    bus_wr(OFS_CODES, 32'h4B4A);
    bus_rd(OFS_CODES, v);
    chk("codes", v[15:0], 32'h4B4A);
    go(4'h3, {S, S, S, S, S, S, K, K});
    repeat (2) exp_plain(20, 8'h30);
    chk_log;
    gap(24, 25, 3);
    chk("warn", {31'h0, warn}, 32'h1);
    bus_rd(OFS_STAT, v);
    chk("queued", v[5:4], 32'h3);
    test_done;
  end
endmodule
